// ---- testbench/css_mem_model.sv ----
// Memory and device model on the far side of the sequencer.
// Assumes registered read and write levels from the sequencer.
module css_mem_model
  import css_pkg::*;
(
  // Clock and bus
  input  wire logic        clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_read,
  input  wire logic        mem_write,
  input  wire logic [7:0]  data_out,
  input  wire logic [7:0]  fill,
  // Read data
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] wr_addr_q[$];
  logic [7:0]  wr_data_q[$];
  logic        wr_prev = 1'b0;
  logic [15:0] addr_prev = 16'h0000;
  logic [7:0]  last_rd = 8'h00;

  // Released bus shows the inverse so stale data never looks valid
  assign mem_rdata = mem_read ? fill : ~last_rd;

  // One record per write cycle; back-to-back cycles split on the address step
  always @(posedge clk) begin
    if (mem_read) last_rd <= fill;
    wr_prev   <= mem_write;
    addr_prev <= mem_addr;
    if (mem_write && (!wr_prev || mem_addr != addr_prev)) begin
      wr_addr_q.push_back(mem_addr);
      wr_data_q.push_back(data_out);
    end
  end
endmodule

// ---- testbench/css_sequencer_sva.sv ----
// Checker for the machine-state sequencer, bound to its ports.
// Assumes one clock domain and the active-low reset rstn.
module css_sequencer_sva
  import css_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Watched outputs
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       dma_in_ack,
  input wire logic       dma_out_ack,
  input wire logic       timing_pulse_first,
  input wire logic       timing_pulse_second,
  input wire logic       interrupt_enable_flag,
  input wire logic       carry_flag,
  input wire logic [1:0] machine_state,
  input wire logic [7:0] accumulator
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Sequencing and bus properties
  // ----------------------------------------
  reset_jam_a: assert property (!$past(rstn) |-> interrupt_enable_flag &&
      machine_state == CSS_EXECUTE_STATE && !timing_pulse_first && !timing_pulse_second)
    else $error("reset values wrong at release");
  ie_held_a: assert property (interrupt_enable_flag)
    else $error("enable flag dropped");
  first_bus_zero_a: assert property ($rose(rstn) |-> ##1
      (data_oe && data_out == CSS_BUS_ZERO) [*2]) else $error("bus not zero after reset");
  fetch_then_exec_a: assert property (machine_state == CSS_FETCH_STATE ##1
      machine_state != CSS_FETCH_STATE |-> machine_state == CSS_EXECUTE_STATE)
    else $error("fetch not followed by execute");
  dma_one_dir_a: assert property (!(dma_in_ack && dma_out_ack))
    else $error("both DMA directions granted");
  ack_in_dma_a: assert property ((dma_in_ack || dma_out_ack) |->
      machine_state == CSS_DMA_STATE) else $error("DMA ack outside DMA state");
  shift_result_a: assert property ($changed(accumulator) |->
      accumulator == {1'b0, $past(accumulator[7:1])}) else $error("shift result wrong");
  carry_lsb_a: assert property ($changed(carry_flag) |->
      carry_flag == $past(accumulator[0])) else $error("carry not from low bit");
endmodule

bind css_sequencer css_sequencer_sva u_sva (.clk(clk), .rstn(rstn), .data_out(data_out),
  .data_oe(data_oe), .dma_in_ack(dma_in_ack), .dma_out_ack(dma_out_ack),
  .timing_pulse_first(timing_pulse_first), .timing_pulse_second(timing_pulse_second),
  .interrupt_enable_flag(interrupt_enable_flag), .carry_flag(carry_flag),
  .machine_state(machine_state), .accumulator(accumulator));

// ---- testbench/tb.sv ----
// Self-checking bench for the sequencer with a memory model.
// Assumes the checker file is compiled too and binds itself.
module tb import css_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, dma_in_req = 0, dma_out_req = 0, int_req = 0, load_mode = 0;
  logic [7:0]  fill = 0, dev_wdata = 0, mem_rdata, data_out, accumulator;
  logic [15:0] mem_addr;
  logic        data_oe, mem_read, mem_write, dma_in_ack, dma_out_ack, carry_flag;
  logic        timing_pulse_first, timing_pulse_second, interrupt_enable_flag;
  logic [1:0]  machine_state;
  int          fails = 0, num_checks = 0, n, k, cnt[4];

  initial forever #20 clk = ~clk;

  css_sequencer dut (.clk(clk), .rstn(rstn), .dma_in_req(dma_in_req),
    .dma_out_req(dma_out_req), .int_req(int_req), .load_mode(load_mode),
    .mem_rdata(mem_rdata), .dev_wdata(dev_wdata), .data_out(data_out), .data_oe(data_oe),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_write(mem_write),
    .dma_in_ack(dma_in_ack), .dma_out_ack(dma_out_ack),
    .timing_pulse_first(timing_pulse_first), .timing_pulse_second(timing_pulse_second),
    .interrupt_enable_flag(interrupt_enable_flag), .carry_flag(carry_flag),
    .machine_state(machine_state), .accumulator(accumulator));
  css_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_read(mem_read),
    .mem_write(mem_write), .data_out(data_out), .fill(fill), .mem_rdata(mem_rdata));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Expected shift-right result: logical shift puts zero on top
  function automatic logic [7:0] shr_exp(logic [7:0] v);
    return v >> 1;
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Counts fetches, first pulses and acks over a span of cycles
  task automatic watch(int cyc);
    cnt = '{default: 0};
    repeat (cyc) begin
      @(negedge clk);
      cnt[0] += int'(machine_state === CSS_FETCH_STATE);
      cnt[1] += int'(timing_pulse_first === 1'b1);
      cnt[2] += int'(dma_in_ack === 1'b1);
      cnt[3] += int'(dma_out_ack === 1'b1);
    end
    // End on a rising edge so callers drive stimulus there
    @(posedge clk);
  endtask

  task automatic do_reset(logic lm, logic [7:0] op);
    rstn <= 1'b0;
    load_mode <= lm;
    fill <= op;
    repeat (10) @(posedge clk);
    check("reset_state", 16'({machine_state, interrupt_enable_flag, timing_pulse_first,
      timing_pulse_second}), 16'h000C);
    rstn <= 1'b1;
    n = 0;
    repeat (3) begin
      @(negedge clk);
      n += int'(data_oe === 1'b1 && data_out === CSS_BUS_ZERO);
    end
    check("first_bus_zero", 16'(n), 16'h0002);
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h0568));
    do_reset(1'b0, 8'h00);
    watch(20);
    watch(30);
    check("idle_fetches", 16'(cnt[0]), 16'h0000);
    repeat ($urandom % 7) @(posedge clk);
    int_req <= 1'b1;
    for (k = 0; k < 20 && machine_state === CSS_EXECUTE_STATE; k++) @(negedge clk);
    check("idle_left_on_int", 16'(machine_state !== CSS_EXECUTE_STATE), 16'h0001);
    @(posedge clk);
    int_req <= 1'b0;
    $display("test idle done");
    do_reset(1'b1, 8'h00);
    dev_wdata <= 8'($urandom);
    watch(20);
    watch(30);
    check("load_fetches", 16'(cnt[0]), 16'h0000);
    check("load_first_pulse", 16'(cnt[1]), 16'h0000);
    mem.wr_addr_q.delete();
    mem.wr_data_q.delete();
    n = 2 + $urandom % 5;
    dma_in_req <= 1'b1;
    for (k = 0; k < 40 * n && mem.wr_addr_q.size() < n; k++) @(negedge clk);
    if (mem.wr_addr_q.size() < n) begin
      fails++;
      stop_test();
    end
    @(posedge clk);
    dma_in_req <= 1'b0;
    watch(12);
    foreach (mem.wr_addr_q[i]) begin
      check("dma_addr", mem.wr_addr_q[i], 16'(i));
      check("dma_data", 16'(mem.wr_data_q[i]), 16'(dev_wdata));
    end
    $display("test load dma done");
    dma_in_req <= 1'b1;
    dma_out_req <= 1'b1;
    watch(40);
    check("prio_out_acks", 16'(cnt[3]), 16'h0000);
    check("prio_in_seen", 16'(cnt[2] > 0), 16'h0001);
    dma_in_req <= 1'b0;
    watch(16);
    check("out_after_in", 16'(cnt[3] > 0), 16'h0001);
    dma_out_req <= 1'b0;
    $display("test dma priority done");
    do_reset(1'b0, 8'hF6);
    for (k = 0; k < 20 && accumulator === CSS_ACC_RESET; k++) @(negedge clk);
    check("shift_one_acc", 16'(accumulator), 16'(shr_exp(CSS_ACC_RESET)));
    check("shift_one_carry", 16'(carry_flag), 16'(CSS_ACC_RESET[0]));
    watch(60);
    check("shift_acc", 16'(accumulator), 16'h0000);
    check("shift_carry", 16'(carry_flag), 16'h0000);
    $display("test shift done");
    stop_test();
  end
endmodule

// ---- verilog/css_pkg.sv ----
// Package for the machine-state sequencer: states, widths, reset values.
// Assumes a single clock domain and an active-low asynchronous reset.
package css_pkg;
  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int            CSS_DATA_W     = 8;
  localparam int            CSS_ADDR_W     = 16;
  localparam int            CSS_OPC_W      = 4;
  localparam logic [7:0]    CSS_BUS_ZERO   = 8'h00;
  localparam logic [15:0]   CSS_ADDR_ZERO  = 16'h0000;
  localparam logic [15:0]   CSS_ADDR_ONE   = 16'h0001;
  localparam logic [3:0]    CSS_IDLE_HI    = 4'h0;
  localparam logic [3:0]    CSS_IDLE_LO    = 4'h0;
  localparam logic [3:0]    CSS_SHR_HI     = 4'hF;
  localparam logic [3:0]    CSS_SHR_LO     = 4'h6;
  localparam logic          CSS_IE_RESET   = 1'b1;
  // Accumulator start value; arbitrary mixed bits so a shift shows at once
  localparam logic [7:0]    CSS_ACC_RESET  = 8'hA5;

  // ----------------------------------------
  // Machine states, Gray order fetch-execute-dma
  // ----------------------------------------
  typedef enum logic [1:0] {
    CSS_FETCH_STATE   = 2'b00,
    CSS_EXECUTE_STATE = 2'b01,
    CSS_DMA_STATE     = 2'b11,
    CSS_INIT_STATE    = 2'b10
  } css_state_e;
endpackage

// ---- verilog/css_sequencer.sv ----
// Machine-state sequencer with reset, idle, load mode and DMA cycles.
// Assumes memory answers within each machine cycle and pins are synchronous-safe
// after the two-stage synchronisers below.
// Operation
// RULE1: Reset forces enable flag, no pulses, execute.
// RULE2: First cycle after reset drives bus zero.
// RULE3: Fetch is always followed by execute.
// RULE4: Idle repeats until DMA or interrupt request.
// RULE5: Load mode suppresses first pulse, awaits DMA.
// RULE6: DMA input wins over DMA output.
// RULE7: Shift right: low bit to carry, zero top.
// RULE8: DMA addresses via register zero, then increments.
module css_sequencer
  import css_pkg::*;
#(
  parameter int DW = CSS_DATA_W,
  parameter int AW = CSS_ADDR_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // External requests and mode pins
  input  wire logic          dma_in_req,
  input  wire logic          dma_out_req,
  input  wire logic          int_req,
  input  wire logic          load_mode,
  // Memory data in
  input  wire logic [DW-1:0] mem_rdata,
  input  wire logic [DW-1:0] dev_wdata,
  // Bus outputs
  output logic      [DW-1:0] data_out,
  output logic               data_oe,
  output logic      [AW-1:0] mem_addr,
  output logic               mem_read,
  output logic               mem_write,
  output logic               dma_in_ack,
  output logic               dma_out_ack,
  // Timing and state
  output logic               timing_pulse_first,
  output logic               timing_pulse_second,
  output logic               interrupt_enable_flag,
  output logic               carry_flag,
  output logic      [1:0]    machine_state,
  output logic      [DW-1:0] accumulator
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;

  // Two stages, no reset: pin levels are settled by the time reset lifts
  always_ff @(posedge clk) begin
    sync1_reg <= {load_mode, int_req, dma_out_req, dma_in_req};
    sync2_reg <= sync1_reg;
  end

  logic din_s;
  logic dout_s;
  logic int_s;
  logic load_s;
  assign din_s  = sync2_reg[0];
  assign dout_s = sync2_reg[1];
  assign int_s  = sync2_reg[2];
  assign load_s = sync2_reg[3];

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  css_state_e   state_reg;
  css_state_e   state_next;
  logic         first_cycle_reg;
  logic         dma_is_in_reg;
  logic [DW-1:0] opcode_reg;
  logic [AW-1:0] reg_zero_reg;
  logic [AW-1:0] pc_reg;
  logic         phase_reg;

  logic is_idle;
  logic is_shr;
  logic dma_any;
  assign is_idle = (opcode_reg == {CSS_IDLE_HI, CSS_IDLE_LO});
  assign is_shr  = (opcode_reg == {CSS_SHR_HI, CSS_SHR_LO});
  assign dma_any = din_s | dout_s;

  // Two clocks per machine cycle: phase 0 then phase 1 ends the cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  // Next-state choice made at the end of each machine cycle
  always_comb begin
    state_next = state_reg;
    if (phase_reg) begin
      unique case (state_reg)
        CSS_INIT_STATE: begin
          state_next = dma_any ? CSS_DMA_STATE : CSS_FETCH_STATE;
        end
        CSS_FETCH_STATE: begin
          state_next = CSS_EXECUTE_STATE;                     // RULE3
        end
        CSS_EXECUTE_STATE: begin
          if (dma_any) begin
            state_next = CSS_DMA_STATE;
          end else if (first_cycle_reg) begin
            // Init cycle over: run mode fetches, load mode stays idle
            state_next = load_s ? CSS_EXECUTE_STATE : CSS_FETCH_STATE; // RULE5
          end else if (is_idle && (load_s || !int_s)) begin
            state_next = CSS_EXECUTE_STATE;                   // RULE4 RULE5
          end else begin
            state_next = CSS_FETCH_STATE;
          end
        end
        CSS_DMA_STATE: begin
          if (dma_any) begin
            state_next = CSS_DMA_STATE;
          end else if (load_s) begin
            state_next = CSS_EXECUTE_STATE;                   // RULE5
          end else begin
            state_next = CSS_FETCH_STATE;
          end
        end
      endcase
    end
  end

  // State register; reset holds execute
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= CSS_EXECUTE_STATE;                         // RULE1
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset leaves one init cycle before the first fetch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_cycle_reg <= 1'b1;
    end else if (phase_reg) begin
      first_cycle_reg <= 1'b0;
    end
  end

  // Latch DMA direction at cycle start; input before output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_is_in_reg <= 1'b0;
    end else if (phase_reg && state_next == CSS_DMA_STATE) begin
      dma_is_in_reg <= din_s;                                 // RULE6
    end
  end

  // ----------------------------------------
  // Registers: opcode, program counter, DMA pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opcode_reg <= CSS_BUS_ZERO;
      pc_reg     <= CSS_ADDR_ZERO;
    end else if (phase_reg && state_reg == CSS_FETCH_STATE) begin
      opcode_reg <= mem_rdata;
      pc_reg     <= pc_reg + CSS_ADDR_ONE;
    end
  end

  // Pointer advances after each completed DMA transfer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_zero_reg <= CSS_ADDR_ZERO;
    end else if (phase_reg && state_reg == CSS_DMA_STATE) begin
      reg_zero_reg <= reg_zero_reg + CSS_ADDR_ONE;           // RULE8
    end
  end

  // ----------------------------------------
  // Accumulator and flags
  // ----------------------------------------
  logic [DW-1:0] shr_val;
  logic          shr_carry;

  css_shifter #(
    .WIDTH (DW)
  ) u_shifter (
    .acc_in    (accumulator),
    .acc_out   (shr_val),
    .carry_out (shr_carry)
  );

  // Shift lands at the end of its execute cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      accumulator <= CSS_ACC_RESET;
      carry_flag  <= 1'b0;
    end else if (phase_reg && state_reg == CSS_EXECUTE_STATE && is_shr
                 && !first_cycle_reg) begin
      accumulator <= shr_val;                                 // RULE7
      carry_flag  <= shr_carry;                               // RULE7
    end
  end

  // Enable flag set by reset; DMA does not touch it here
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_flag <= CSS_IE_RESET;                  // RULE1
    end else begin
      interrupt_enable_flag <= interrupt_enable_flag;
    end
  end

  // ----------------------------------------
  // Timing pulses, registered
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timing_pulse_first  <= 1'b0;                            // RULE1
      timing_pulse_second <= 1'b0;                            // RULE1
    end else begin
      // First pulse dropped in load mode so memory sees no new cycle
      timing_pulse_first  <= !phase_reg && !(load_s && state_next != CSS_FETCH_STATE); // RULE5
      timing_pulse_second <= phase_reg;
    end
  end

  // ----------------------------------------
  // Bus drive, registered at phase start
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      data_out  <= CSS_BUS_ZERO;
      data_oe   <= 1'b0;
      mem_addr  <= CSS_ADDR_ZERO;
      mem_read  <= 1'b0;
      mem_write <= 1'b0;
    end else if (first_cycle_reg) begin
      data_out  <= CSS_BUS_ZERO;                              // RULE2
      data_oe   <= 1'b1;                                      // RULE2
      mem_addr  <= CSS_ADDR_ZERO;
      mem_read  <= 1'b0;
      mem_write <= 1'b0;
    end else begin
      data_oe   <= 1'b0;
      mem_read  <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= pc_reg;
      data_out  <= CSS_BUS_ZERO;
      if (state_reg == CSS_DMA_STATE) begin
        mem_addr  <= reg_zero_reg;                            // RULE8
        mem_write <= dma_is_in_reg;
        mem_read  <= !dma_is_in_reg;
        data_out  <= dev_wdata;
        data_oe   <= dma_is_in_reg;
      end else if (state_reg == CSS_FETCH_STATE) begin
        mem_read  <= 1'b1;
      end
    end
  end

  // Acks mark the DMA cycle direction
  assign dma_in_ack    = (state_reg == CSS_DMA_STATE) && dma_is_in_reg;
  assign dma_out_ack   = (state_reg == CSS_DMA_STATE) && !dma_is_in_reg;
  assign machine_state = state_reg;
endmodule

// ---- verilog/css_shifter.sv ----
// Shift-right unit for the accumulator.
// Assumes the caller loads the result only in the shift execute cycle.
module css_shifter
  import css_pkg::*;
#(
  parameter int WIDTH = CSS_DATA_W
) (
  // Operand
  input  wire logic [WIDTH-1:0] acc_in,
  // Result
  output logic      [WIDTH-1:0] acc_out,
  output logic                  carry_out
);
  // Zero enters at the top, low bit leaves as carry
  assign acc_out   = {1'b0, acc_in[WIDTH-1:1]};  // RULE7
  assign carry_out = acc_in[0];                  // RULE7
endmodule
